//--- rtl/uiif_params.svh
// Constants for the interrupt identification and FIFO control block
// Operation
// - Identifier bits 7:6 read 00 with FIFOs off, 11 with FIFOs on.
// - Identifier field reports highest-priority pending source code.
// - Reserved identifier codes never appear in the identifier field.
// - Line error raises 0110, highest, held until line status read, or buffer read when clear mode allows it.
// - Code 0100 on data available or trigger reached; clears when consumed.
// - Code 1100 on idle non-empty receive FIFO; clears on buffer read.
// - Timeout counts ((wl*7)-2)*8 + (trigger-count)*8+1 baud cycles.
// - Holding empty raises 0010; cleared by identifier read showing 0010, or holding write.
// - Identifier reads 0x001 after reset.
// - FIFO control shares offset 0x008, write-only, resets to 0x000.
// - Receive threshold bits 7:6 select 1, 4, 8 or 14 characters.
// - Transmit threshold bits 5:4 select 0, 2, 4 or 8 characters.
// - Writing 1 to bit 2 flushes transmit FIFO; self clearing.
// - Writing 1 to bit 1 flushes receive FIFO; self clearing.
// - Enable bit 0 gates FIFOs and bits 7:4 and 2:1; change empties both.
// - Receive data enable gates data-available and timeout sources.
// - Clear mode picks buffer-or-status read, or status read only.
`ifndef UIIF_PARAMS_SVH
`define UIIF_PARAMS_SVH
`define UIIF_OFS_IDENT 6'h08
`define UIIF_OFS_IEN 6'h04
`define UIIF_OFS_STAT 6'h20
`define UIIF_OFS_MASK 6'h24
`define UIIF_IDENT_RST 8'h01
`define UIIF_FCR_RST 8'h00
`define UIIF_ID_NONE 4'h1
`define UIIF_ID_LINE 4'h6
`define UIIF_ID_DATA 4'h4
`define UIIF_ID_TMO 4'hC
`define UIIF_ID_THE 4'h2
`define UIIF_ID_BUSY 4'h7
`define UIIF_ID_MODEM 4'h0
`define UIIF_FIFO_ON 2'h3
`define UIIF_FIFO_OFF 2'h0
`define UIIF_BIT_EN 0
`define UIIF_BIT_RXF 1
`define UIIF_BIT_TXF 2
`define UIIF_IEN_RDA 0
`define UIIF_IEN_THE 1
`define UIIF_IEN_RLS 2
`define UIIF_IEN_MS 3
`define UIIF_IEN_CLRMD 4
`define UIIF_RXT_0 5'h01
`define UIIF_RXT_1 5'h04
`define UIIF_RXT_2 5'h08
`define UIIF_RXT_3 5'h0E
`define UIIF_TXT_0 5'h00
`define UIIF_TXT_1 5'h02
`define UIIF_TXT_2 5'h04
`define UIIF_TXT_3 5'h08
`define UIIF_WL_MUL 5'h07
`define UIIF_WL_SUB 12'h002
`define UIIF_CH_MUL 12'h008
`define UIIF_TMO_ADD 12'h001
`define UIIF_WL_BASE 12'h005
`endif

//--- rtl/uiif_pkg.sv
// Types for the interrupt identification and FIFO control block
package uiif_pkg;
  typedef struct packed {
    logic [7:0] ident_rd;
    logic [4:0] ien;
    logic [7:0] fcr;
    logic line_err;
    logic the_pend;
    logic tx_empty_d1;
    logic [11:0] tmo_cnt;
    logic tmo_pend;
    logic [3:0] stat;
    logic [3:0] mask;
    logic ack;
    logic [31:0] dat;
  } uiif_state_s;
endpackage

//--- rtl/uiif_core.sv
// Interrupt identification, FIFO control and Wishbone register slave
//
// Local design decision: register access over Wishbone.
`timescale 1ns/1ps
`include "uiif_params.svh"
module uiif_core
  import uiif_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [5:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Sources from the UART datapath (same clock)
  input wire logic line_err_i,
  input wire logic rx_avail_i,
  input wire logic [4:0] rx_count_i,
  input wire logic rx_moved_i,
  input wire logic baud_tick_i,
  input wire logic [1:0] word_len_i,
  input wire logic tx_empty_i,
  input wire logic busy_i,
  input wire logic modem_i,
  input wire logic line_status_rd_i,
  input wire logic rx_buffer_rd_i,
  input wire logic tx_holding_wr_i,
  // FIFO control towards the datapath
  output logic queues_on_o,
  output logic [4:0] rx_fill_threshold_o,
  output logic [4:0] tx_fill_threshold_o,
  output logic tx_flush_o,
  output logic rx_flush_o,
  output logic status_clear_mode_o,
  // Interrupt
  output logic irq_o
);
  uiif_state_s q, d;
  logic req, wr, rd, id_rd, fcr_wr;
  logic en_now, en_new, rx_trig, rx_hit, tmo_hit;
  logic [3:0] code;
  logic [3:0] ev;
  logic [11:0] tmo_len;
  logic [4:0] thr_rx;

  // Checks below sample on the bus clock and rest during reset, except the reset-value checks
  default clocking chk_cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // One request per Wishbone cycle; ack is held for one cycle only
  assign req = cyc_i && stb_i && !q.ack;
  assign wr = req && we_i && sel_i[0];
  assign rd = req && !we_i;
  assign id_rd = rd && (adr_i == `UIIF_OFS_IDENT);
  assign fcr_wr = wr && (adr_i == `UIIF_OFS_IDENT);
  assign en_now = q.fcr[`UIIF_BIT_EN];
  assign en_new = dat_i[`UIIF_BIT_EN];

  // Receive and transmit threshold decode
  always_comb
  begin
    case (q.fcr[7:6])
      2'h0: thr_rx = `UIIF_RXT_0;
      2'h1: thr_rx = `UIIF_RXT_1;
      2'h2: thr_rx = `UIIF_RXT_2;
      default: thr_rx = `UIIF_RXT_3;
    endcase
    case (q.fcr[5:4])
      2'h0: tx_fill_threshold_o = `UIIF_TXT_0;
      2'h1: tx_fill_threshold_o = `UIIF_TXT_1;
      2'h2: tx_fill_threshold_o = `UIIF_TXT_2;
      default: tx_fill_threshold_o = `UIIF_TXT_3;
    endcase
  end

  // Timeout length; a count above the threshold adds nothing
  always_comb
  begin
    tmo_len = ((({7'h00, word_len_i} + 9'(`UIIF_WL_BASE))
      * 12'(`UIIF_WL_MUL)) - `UIIF_WL_SUB) * `UIIF_CH_MUL
      + `UIIF_TMO_ADD;
    if (thr_rx > rx_count_i)
      tmo_len = tmo_len + 12'(thr_rx - rx_count_i) * `UIIF_CH_MUL;
  end

  // Data available: level in FIFO mode, any byte otherwise
  assign rx_trig = en_now ? (rx_count_i >= thr_rx) : rx_avail_i;
  assign rx_hit = rx_trig && q.ien[`UIIF_IEN_RDA];
  assign tmo_hit = q.tmo_pend && q.ien[`UIIF_IEN_RDA];

  // Priority encoder; only listed codes can leave it
  always_comb
  begin
    if (q.line_err && q.ien[`UIIF_IEN_RLS])
      code = `UIIF_ID_LINE;
    else if (tmo_hit)
      code = `UIIF_ID_TMO;
    else if (rx_hit)
      code = `UIIF_ID_DATA;
    else if (q.the_pend && q.ien[`UIIF_IEN_THE])
      code = `UIIF_ID_THE;
    else if (busy_i)
      code = `UIIF_ID_BUSY;
    else if (modem_i && q.ien[`UIIF_IEN_MS])
      code = `UIIF_ID_MODEM;
    else
      code = `UIIF_ID_NONE;
  end

  // Events for the sticky status, bit 0 up: line, data, timeout, holding empty
  assign ev = {q.the_pend, tmo_hit, rx_hit, q.line_err};

  // Next-state logic
  always_comb
  begin
    d = q;
    d.ack = req;
    d.fcr[`UIIF_BIT_TXF] = 1'b0;
    d.fcr[`UIIF_BIT_RXF] = 1'b0;
    d.tx_empty_d1 = tx_empty_i;
    if (fcr_wr)
    begin
      d.fcr = {dat_i[7:3], 3'h0};
      d.fcr[`UIIF_BIT_EN] = en_new;
      if (en_new)
      begin
        d.fcr[`UIIF_BIT_TXF] = dat_i[`UIIF_BIT_TXF];
        d.fcr[`UIIF_BIT_RXF] = dat_i[`UIIF_BIT_RXF];
      end
      else
        d.fcr[7:4] = 4'h0;
      if (en_new != en_now)
      begin
        d.fcr[`UIIF_BIT_TXF] = 1'b1;
        d.fcr[`UIIF_BIT_RXF] = 1'b1;
      end
    end
    if (wr && adr_i == `UIIF_OFS_IEN)
      d.ien = dat_i[4:0];
    // Line error: clear first so a new error in the read cycle wins
    if (line_status_rd_i ||
        (rx_buffer_rd_i && !q.ien[`UIIF_IEN_CLRMD]))
      d.line_err = 1'b0;
    if (line_err_i)
      d.line_err = 1'b1;
    // Holding empty pends on the rising edge of empty
    if (id_rd && code == `UIIF_ID_THE)
      d.the_pend = 1'b0;
    if (tx_holding_wr_i)
      d.the_pend = 1'b0;
    if (tx_empty_i && !q.tx_empty_d1)
      d.the_pend = 1'b1;
    // Character timeout counter in baud ticks
    if (!en_now || rx_count_i == 5'h00 || rx_moved_i || rx_buffer_rd_i)
      d.tmo_cnt = 12'h000;
    else if (baud_tick_i && !q.tmo_pend)
      d.tmo_cnt = q.tmo_cnt + 12'h001;
    if (rx_buffer_rd_i || !en_now)
      d.tmo_pend = 1'b0;
    else if (baud_tick_i && rx_count_i != 5'h00 &&
             q.tmo_cnt + 12'h001 >= tmo_len)
      d.tmo_pend = 1'b1;
    // Sticky status: write one clears, new event wins
    if (wr && adr_i == `UIIF_OFS_STAT)
      d.stat = q.stat & ~dat_i[3:0];
    d.stat = d.stat | ev;
    if (wr && adr_i == `UIIF_OFS_MASK)
      d.mask = dat_i[3:0];
    // Read mux; identifier snapshot is the value seen by software
    d.ident_rd = {(en_now ? `UIIF_FIFO_ON : `UIIF_FIFO_OFF),
                  2'h0, code};
    d.dat = 32'h0000_0000;
    if (rd)
      case (adr_i)
        `UIIF_OFS_IDENT: d.dat = {24'h0, d.ident_rd};
        `UIIF_OFS_IEN: d.dat = {27'h0, q.ien};
        `UIIF_OFS_STAT: d.dat = {28'h0, q.stat};
        `UIIF_OFS_MASK: d.dat = {28'h0, q.mask};
        default: d.dat = 32'h0000_0000;
      endcase
  end

  // State register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q <= '0;
      q.ident_rd <= `UIIF_IDENT_RST;
      q.fcr <= `UIIF_FCR_RST;
    end
    else
      q <= d;
  end

  // Outputs
  assign dat_o = q.dat;
  assign ack_o = q.ack;
  assign queues_on_o = en_now;
  assign rx_fill_threshold_o = thr_rx;
  assign tx_flush_o = q.fcr[`UIIF_BIT_TXF];
  assign rx_flush_o = q.fcr[`UIIF_BIT_RXF];
  assign status_clear_mode_o = q.ien[`UIIF_IEN_CLRMD];
  assign irq_o = |(q.stat & q.mask);

  // Checks on the identifier field
  // Status field follows enable, one cycle behind a control write
  chk_fifo_status: assert property (
    q.ident_rd[7:6] == (en_now ? `UIIF_FIFO_ON : `UIIF_FIFO_OFF)
      || $past(fcr_wr))
    else $error("fifo status field wrong");
  // Only listed codes may leave the encoder
  chk_code_legal: assert property (
    code inside {`UIIF_ID_TMO, `UIIF_ID_BUSY, `UIIF_ID_LINE, `UIIF_ID_DATA,
      `UIIF_ID_THE, `UIIF_ID_NONE, `UIIF_ID_MODEM})
    else $error("reserved identifier code");
  // Enabled line error outranks everything
  chk_line_first: assert property (
    q.line_err && q.ien[`UIIF_IEN_RLS] |-> code == `UIIF_ID_LINE)
    else $error("line error not top priority");
  // Timeout wins over data available below line error
  chk_timeout_code: assert property (
    tmo_hit && !(q.line_err && q.ien[`UIIF_IEN_RLS]) |-> code == `UIIF_ID_TMO)
    else $error("timeout code missing");
  // Receive enable masks both receive sources
  chk_gate_rda: assert property (
    !q.ien[`UIIF_IEN_RDA] |-> code != `UIIF_ID_DATA && code != `UIIF_ID_TMO)
    else $error("receive sources not gated");
  // Nothing-pending code only when busy, data and timeout sources are quiet
  chk_none_idle: assert property (
    code == `UIIF_ID_NONE |-> !busy_i && !rx_hit && !tmo_hit)
    else $error("pending source hidden");
  // Busy detect only loses to holding empty or higher
  chk_busy_rank: assert property (
    busy_i |-> code inside {`UIIF_ID_LINE, `UIIF_ID_TMO, `UIIF_ID_DATA,
      `UIIF_ID_THE, `UIIF_ID_BUSY})
    else $error("busy detect misranked");
  // Modem only shows when busy detect is absent
  chk_modem_low: assert property (
    code == `UIIF_ID_MODEM |-> !busy_i)
    else $error("modem above busy detect");

  // Checks on pending flags
  // A holding write clears unless empty rises at once
  chk_thr_clear: assert property (
    tx_holding_wr_i && !(tx_empty_i && !q.tx_empty_d1) |=> !q.the_pend)
    else $error("holding empty not cleared");
  // Rising empty always pends, set wins over clears
  chk_thr_pend: assert property (
    tx_empty_i && !q.tx_empty_d1 |=> q.the_pend)
    else $error("holding empty not pending");
  // Any line error pends next cycle
  chk_line_set: assert property (
    line_err_i |=> q.line_err)
    else $error("line error lost");
  // In status-only mode a buffer read keeps the error
  chk_line_keep: assert property (
    q.line_err && q.ien[`UIIF_IEN_CLRMD] && !line_status_rd_i
      |=> q.line_err)
    else $error("line error cleared in wrong mode");
  // Buffer read drops the timeout indication
  chk_tmo_clear: assert property (
    rx_buffer_rd_i |=> !q.tmo_pend)
    else $error("timeout not cleared by read");
  // Timeout never pends with FIFOs off
  chk_tmo_gate: assert property (
    !en_now |=> !q.tmo_pend)
    else $error("timeout pending with fifo off");

  // Checks on FIFO control
  // Receive flush lasts one cycle unless rewritten
  chk_flush_self: assert property (
    rx_flush_o |=> !rx_flush_o || $past(fcr_wr))
    else $error("receive flush not self clearing");
  // Transmit flush lasts one cycle unless rewritten
  chk_tx_self: assert property (
    tx_flush_o |=> !tx_flush_o || $past(fcr_wr))
    else $error("transmit flush not self clearing");
  // Enable change empties both queues
  chk_en_flush: assert property (
    fcr_wr && en_new != en_now |=> tx_flush_o && rx_flush_o)
    else $error("enable change did not flush");
  // Transmit flush request pulses once
  chk_tx_flush: assert property (
    fcr_wr && en_new && dat_i[`UIIF_BIT_TXF] |=> tx_flush_o ##1 !tx_flush_o
      || $past(fcr_wr))
    else $error("transmit flush pulse wrong");
  // Writes with FIFOs staying off flush nothing
  chk_off_no_flush: assert property (
    fcr_wr && !en_new && !en_now |=> !tx_flush_o && !rx_flush_o)
    else $error("flush while fifo off");
  // Control bits 7:4 are held clear while disabled
  chk_off_bits: assert property (
    !en_now |-> q.fcr[7:4] == 4'h0)
    else $error("control bits kept with fifo off");
  // Receive threshold only takes the listed fills
  chk_rx_thr_map: assert property (
    rx_fill_threshold_o inside {`UIIF_RXT_0, `UIIF_RXT_1, `UIIF_RXT_2,
      `UIIF_RXT_3})
    else $error("receive threshold out of set");
  // Transmit threshold only takes the listed fills
  chk_tx_thr_map: assert property (
    tx_fill_threshold_o inside {`UIIF_TXT_0, `UIIF_TXT_1, `UIIF_TXT_2,
      `UIIF_TXT_3})
    else $error("transmit threshold out of set");

  // Checks on reset values; these must run while reset is high
  chk_ident_reset: assert property (
    disable iff (1'b0) $past(rst_i) |-> q.ident_rd == `UIIF_IDENT_RST)
    else $error("identifier reset value wrong");
  // Control register comes out of reset cleared
  chk_fcr_reset: assert property (
    disable iff (1'b0) $past(rst_i) |-> q.fcr == `UIIF_FCR_RST)
    else $error("fifo control reset value wrong");

  // Checks on the register bus
  // Every taken request is answered on the next edge
  chk_req_ack: assert property (
    req |=> ack_o)
    else $error("request not acknowledged");
  // Acknowledge never stands two cycles
  chk_ack_single: assert property (
    ack_o |=> !ack_o)
    else $error("acknowledge too long");
  // Read data is zero outside an acknowledge
  chk_dat_idle: assert property (
    !ack_o |-> dat_o == 32'h0000_0000)
    else $error("read data outside acknowledge");
  // Only byte 0 ever carries data
  chk_upper_zero: assert property (
    dat_o[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  // The shared offset reads back the identifier
  chk_ident_read: assert property (
    id_rd |=> dat_o[7:0] == q.ident_rd)
    else $error("shared offset read wrong");

  // Checks on the sticky status
  // A new event lands in the status register
  chk_sticky_set: assert property (
    (ev & ~q.stat) != 4'h0 |=> (q.stat & $past(ev)) == $past(ev))
    else $error("status event lost");
  // Status bits drop only through a status write
  chk_sticky_hold: assert property (
    !(wr && adr_i == `UIIF_OFS_STAT) |=> ($past(q.stat) & ~q.stat) == 4'h0)
    else $error("status bit dropped by itself");

  // Main scenarios worth seeing
  cov_timeout: cover property (code == `UIIF_ID_TMO);
  cov_line: cover property (code == `UIIF_ID_LINE);
  cov_irq: cover property ($rose(irq_o));
  cov_thr: cover property (code == `UIIF_ID_THE);
  cov_flush: cover property (rx_flush_o && tx_flush_o);
endmodule // uiif_core

//--- verif/uiif_dp_model.sv
// Partner model of the UART datapath that feeds the block
`timescale 1ns/1ps
module uiif_dp_model (
  // Clock and flush requests from the block
  input wire logic clk_i,
  input wire logic rx_flush_i,
  input wire logic tx_flush_i,
  // Strobes: line err, status rd, buffer rd, holding wr, byte moved
  output logic [4:0] pls_o,
  // Receive fill
  output logic [4:0] rx_count_o
);
  int nrx = 0;
  int ntx = 0;
  initial pls_o = 5'h00;
  initial rx_count_o = 5'h00;
  // Strobes last one cycle; the bench only raises them while all are low
  always @(posedge clk_i)
  begin
    if (pls_o != 5'h00)
      pls_o <= 5'h00;
    if (rx_flush_i)
      rx_count_o <= 5'h00;
    else if (pls_o[2] && rx_count_o != 5'h00)
      rx_count_o <= rx_count_o - 5'h01;
    nrx <= nrx + int'(rx_flush_i);
    ntx <= ntx + int'(tx_flush_i);
  end
endmodule // uiif_dp_model

//--- verif/test_uart_irq_ident_fifo_ctrl.sv
// Testbench for the identification and FIFO control block
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin bad_count++; \
  $display("mismatch %s exp %0h got %0h", n, e, s); end end
module test_uart_irq_ident_fifo_ctrl;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ra = 0, te = 0;
  logic bz = 0, md = 0, rxf, txf, qon, irq, ack, scm;
  logic [1:0] wl = 2'h0;
  logic [5:0] adr = 6'h00;
  logic [31:0] wd = 32'h0, dout, r;
  logic [4:0] pls, cnt, rxt, txt;
  int bad_count = 0, checks = 0, n0, n1;
  logic [4:0] rxtab [4] = '{5'h01, 5'h04, 5'h08, 5'h0E};
  logic [4:0] txtab [4] = '{5'h00, 5'h02, 5'h04, 5'h08};
  always #50 clk_i = ~clk_i;
  uiif_dp_model dp (.clk_i(clk_i), .rx_flush_i(rxf), .tx_flush_i(txf),
    .pls_o(pls), .rx_count_o(cnt));
  uiif_core uiif_core_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(wd),
    .dat_o(dout), .ack_o(ack), .line_err_i(pls[0]), .rx_avail_i(ra),
    .rx_count_i(cnt), .rx_moved_i(pls[4]), .baud_tick_i(1'b1),
    .word_len_i(wl), .tx_empty_i(te), .busy_i(bz), .modem_i(md),
    .line_status_rd_i(pls[1]), .rx_buffer_rd_i(pls[2]),
    .tx_holding_wr_i(pls[3]), .queues_on_o(qon), .rx_fill_threshold_o(rxt),
    .tx_fill_threshold_o(txt), .tx_flush_o(txf), .rx_flush_o(rxf),
    .status_clear_mode_o(scm), .irq_o(irq));
  // Classic cycle; the request stands until ack is sampled at an edge
  task wb(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    begin
      n = 0;
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wd <= d;
      do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 50);
      if (n == 50) bad_count++;
      r = dout;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
      @(posedge clk_i);
    end
  endtask
  task rd(input logic [5:0] a, input logic [31:0] e);
    begin wb(1'b0, a, 32'h0); `CHK("read", e, r) end
  endtask
  task tick(input int k);
    repeat (k) @(posedge clk_i);
  endtask
  task close_out;
    begin
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  // Watchdog; the whole sequence needs about five hundred cycles
  initial
  begin
    tick(5000);
    bad_count++;
    close_out;
  end
  // Main sequence
  initial
  begin
    tick(10); rst_i <= 1'b0; tick(1);
    rd(6'h08, 32'h01);
    rd(6'h3C, 32'h00);
    $display("test reset done");
    for (int i = 0; i < 4; i++)
    begin
      wb(1'b1, 6'h08, 32'h51 * i | 32'h01);
      `CHK("rx threshold", rxtab[i], rxt)
      `CHK("tx threshold", txtab[i], txt)
      rd(6'h08, 32'hC1);
    end
    n0 = dp.nrx; n1 = dp.ntx;
    wb(1'b1, 6'h08, 32'h01);
    `CHK("no flush", n0 + n1, dp.nrx + dp.ntx)
    dp.rx_count_o <= 5'h03; wb(1'b1, 6'h08, 32'h03); tick(1);
    `CHK("rx flush", n0 + 1, dp.nrx)
    `CHK("rx empty", 5'h00, cnt)
    wb(1'b1, 6'h08, 32'h05); tick(1);
    `CHK("tx flush", n1 + 1, dp.ntx)
    wb(1'b1, 6'h08, 32'h00); tick(1);
    `CHK("off flush", n0 + n1 + 4, dp.nrx + dp.ntx)
    `CHK("fifo off", 1'b0, qon)
    rd(6'h08, 32'h01);
    $display("test fifo control done");
    wb(1'b1, 6'h04, 32'h0F);
    ra <= 1'b1; te <= 1'b1; bz <= 1'b1; md <= 1'b1; dp.pls_o <= 5'h01;
    tick(2);
    rd(6'h08, 32'h06);
    dp.pls_o <= 5'h02; tick(2);
    rd(6'h08, 32'h04);
    ra <= 1'b0; tick(2);
    rd(6'h08, 32'h02);
    rd(6'h08, 32'h07);
    bz <= 1'b0; tick(2);
    rd(6'h08, 32'h00);
    md <= 1'b0; te <= 1'b0; tick(2);
    te <= 1'b1; tick(2); dp.pls_o <= 5'h08; tick(2);
    rd(6'h08, 32'h01);
    wb(1'b1, 6'h04, 32'h0E); ra <= 1'b1; tick(2);
    rd(6'h08, 32'h01);
    ra <= 1'b0;
    $display("test priority done");
    wb(1'b1, 6'h20, 32'h0F); wb(1'b1, 6'h24, 32'h01);
    `CHK("irq idle", 1'b0, irq)
    dp.pls_o <= 5'h01; tick(3);
    `CHK("irq set", 1'b1, irq)
    wb(1'b1, 6'h24, 32'h00); tick(1);
    `CHK("irq masked", 1'b0, irq)
    wb(1'b1, 6'h24, 32'h01); tick(1);
    `CHK("irq unmasked", 1'b1, irq)
    dp.pls_o <= 5'h02; tick(2);
    wb(1'b1, 6'h20, 32'h01); tick(1);
    `CHK("irq cleared", 1'b0, irq)
    wb(1'b1, 6'h04, 32'h14); dp.pls_o <= 5'h01; tick(2);
    dp.pls_o <= 5'h04; tick(2);
    `CHK("clear mode", 1'b1, scm)
    rd(6'h08, 32'h06);
    wb(1'b1, 6'h04, 32'h04); dp.pls_o <= 5'h04; tick(2);
    rd(6'h08, 32'h01);
    $display("test interrupt done");
    wl <= 2'h1;
    wb(1'b1, 6'h04, 32'h01); wb(1'b1, 6'h08, 32'h41); tick(1);
    dp.rx_count_o <= 5'h01; dp.pls_o <= 5'h10;
    tick(344); // (6 * 7 - 2) * 8 + (4 - 1) * 8 + 1 = 345 ticks
    rd(6'h08, 32'hC1);
    rd(6'h08, 32'hCC);
    dp.pls_o <= 5'h04; tick(2);
    rd(6'h08, 32'hC1);
    $display("test timeout done");
    close_out;
  end
endmodule // test_uart_irq_ident_fifo_ctrl
